// File: prfi_frame_input.sv
// Purpose : Capture frames from one parallel RGB port, redisplay per frame
// Assumes : Source keeps periodic syncs; vsync edge marks each frame
// Notes   : Frames beyond FRAME_WORDS pixels are clipped at the last word
`timescale 1ns/1ps
module prfi_frame_input (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_pattern_mode,
    input  wire logic                          port_one_pixel_clock,
    input  wire prfi_pkg::prfi_pixel_t         port_one_colour_inputs,
    input  wire logic                          port_one_data_valid,
    input  wire logic                          port_one_vertical_sync,
    input  wire logic                          port_one_horizontal_sync,
    output prfi_pkg::prfi_pixel_t              o_pix_data,
    output logic                               o_pix_valid,
    output logic                               o_frame_start,
    output logic                               o_frame_repeat,
    output logic                               o_pattern_trigger
);
    import prfi_pkg::*;

    // ==========================================================
    // Shared arithmetic
    function automatic logic [ADDR_BITS-1:0] addr_inc(
        input logic [ADDR_BITS-1:0] a
    );
        return a + 8'h01;
    endfunction : addr_inc

    // ==========================================================
    // Pixel domain: reset arrives through two flops
    // Pixel clock is assumed to run through reset, as syncs never stop
    logic [1:0] rst_px_ff;
    wire logic  px_rst = rst_px_ff[1];

    always_ff @(posedge port_one_pixel_clock) begin
        rst_px_ff <= {rst_px_ff[0], i_rst};
    end

    // ==========================================================
    // Pixel domain: input capture on the port's own clock
    prfi_port_t           in_ff;
    logic                 vs_d_ff;
    logic [1:0]           mode_px_ff;
    logic                 wbank_ff;
    logic [ADDR_BITS-1:0] waddr_ff;
    logic                 got_pix_ff;
    logic                 vs_tog_ff;
    logic                 new_frame_ff;

    wire logic          vs_rise  = in_ff.vsync & ~vs_d_ff;
    wire logic          pat_px   = mode_px_ff[1];
    wire logic          wr_en    = in_ff.valid;
    wire prfi_pixel_t   pix_in   = in_ff.colour;
    // Upper eight bits per channel packed low, top six bits zero
    wire logic [PAT_BITS-1:0] pat_word = {
        pix_in.red[CH_BITS-1 -: PAT_CH_BITS],
        pix_in.green[CH_BITS-1 -: PAT_CH_BITS],
        pix_in.blue[CH_BITS-1 -: PAT_CH_BITS]};
    wire logic [PIX_BITS-1:0] wr_word = pat_px
        ? {{(PIX_BITS-PAT_BITS){1'b0}}, pat_word}
        : pix_in;
    wire logic [MEM_ABITS-1:0] wr_addr = {wbank_ff, waddr_ff};

    // Inputs are synchronous to the pixel clock, so one capture stage
    always_ff @(posedge port_one_pixel_clock) begin
        in_ff <= '{colour: port_one_colour_inputs,
                   vsync:  port_one_vertical_sync,
                   hsync:  port_one_horizontal_sync,
                   valid:  port_one_data_valid};
        vs_d_ff    <= in_ff.vsync;
        mode_px_ff <= {mode_px_ff[0], i_pattern_mode};
    end

    // Reset wins over a vsync in the same pixel clock
    always_ff @(posedge port_one_pixel_clock) begin
        if (px_rst) begin
            waddr_ff     <= ADDR_ZERO;
            got_pix_ff   <= 1'b0;
            wbank_ff     <= 1'b0;
            new_frame_ff <= 1'b0;
            vs_tog_ff    <= 1'b0;
        end else if (vs_rise) begin
            waddr_ff     <= ADDR_ZERO;
            got_pix_ff   <= 1'b0;
            wbank_ff     <= wbank_ff ^ got_pix_ff;
            new_frame_ff <= got_pix_ff;
            vs_tog_ff    <= ~vs_tog_ff;
        end else if (wr_en) begin
            got_pix_ff <= 1'b1;
            if (waddr_ff != ADDR_LAST) begin
                waddr_ff <= addr_inc(waddr_ff);
            end
        end
    end

    // ==========================================================
    // Frame store
    logic [MEM_ABITS-1:0] raddr;
    logic [PIX_BITS-1:0]  rdata;

    prfi_frame_mem u_mem (
        .i_wclk  (port_one_pixel_clock),
        .i_we    (wr_en),
        .i_waddr (wr_addr),
        .i_wdata (wr_word),
        .i_clk   (i_clk),
        .i_raddr (raddr),
        .o_rdata (rdata)
    );

    // ==========================================================
    // System domain: frame event crossing
    // Pixel flops clear two pixel clocks after i_rst falls; the hold
    // keeps their unknown start out of the crossing. Limitation: the
    // pixel clock must be faster than one fifteenth of i_clk.
    logic [4:0] hold_ff;
    wire logic  sync_hold = (hold_ff != 5'h00);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_ff <= SYNC_HOLD;
        end else if (sync_hold) begin
            hold_ff <= hold_ff - 5'h01;
        end
    end

    // Toggle runs four stages so the new-frame level settles first
    logic [3:0] tog_sync_ff;
    logic [1:0] new_sync_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst || sync_hold) begin
            tog_sync_ff <= 4'h0;
            new_sync_ff <= 2'h0;
        end else begin
            tog_sync_ff <= {tog_sync_ff[2:0], vs_tog_ff};
            new_sync_ff <= {new_sync_ff[0], new_frame_ff};
        end
    end

    wire logic frame_evt = tog_sync_ff[3] ^ tog_sync_ff[2];
    wire logic frame_new = new_sync_ff[1];

    // ==========================================================
    // System domain: readout of the front bank once per frame
    prfi_rd_state_t       state_ff;
    prfi_rd_state_t       nxt_state;
    logic                 fbank_ff;
    logic [ADDR_BITS-1:0] raddr_ff;
    logic                 rd_live_ff;

    // Bank flips only when the closing frame brought pixels
    wire logic nxt_fbank = (frame_evt & frame_new) ? ~fbank_ff : fbank_ff;
    assign raddr = {fbank_ff, raddr_ff};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PRFI_IDLE: begin
                if (frame_evt) begin
                    nxt_state = PRFI_READ;
                end
            end
            PRFI_READ: begin
                if (raddr_ff == ADDR_LAST - 8'h01) begin
                    nxt_state = PRFI_LAST;
                end
            end
            PRFI_LAST: begin
                nxt_state = PRFI_IDLE;
            end
            default: begin
                nxt_state = PRFI_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff   <= PRFI_IDLE;
            fbank_ff   <= 1'b1;
            raddr_ff   <= ADDR_ZERO;
            rd_live_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            fbank_ff   <= nxt_fbank;
            raddr_ff   <= (state_ff == PRFI_IDLE) ? ADDR_ZERO
                                                  : addr_inc(raddr_ff);
            rd_live_ff <= (state_ff != PRFI_IDLE);
        end
    end

    // ==========================================================
    // Outputs, all registered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pix_data        <= '0;
            o_pix_valid       <= 1'b0;
            o_frame_start     <= 1'b0;
            o_frame_repeat    <= 1'b0;
            o_pattern_trigger <= 1'b0;
        end else begin
            o_pix_data        <= rdata;
            o_pix_valid       <= rd_live_ff;
            o_frame_start     <= frame_evt;
            o_pattern_trigger <= frame_evt & i_pattern_mode;
            // Repeat flag holds until the next frame start
            if (frame_evt) begin
                o_frame_repeat <= ~frame_new;
            end
        end
    end
endmodule : prfi_frame_input

// File: prfi_frame_input_assertions.sv
// Purpose : Readout timing checks
// Assumes : System clock side only
// Notes   : Replayed frames skip the width check
`timescale 1ns/1ps
module prfi_chk (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_pattern_mode,
    input wire prfi_pkg::prfi_pixel_t o_pix_data,
    input wire logic                  o_pix_valid,
    input wire logic                  o_frame_start,
    input wire logic                  o_frame_repeat,
    input wire logic                  o_pattern_trigger
);
    import prfi_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ====================
    // Readout
    sequence s_gap; !o_pix_valid [*2]; endsequence
    sequence s_run; o_pix_valid [*8]; endsequence
    property p_run; o_frame_start |-> s_gap ##1 s_run; endproperty
    property p_one; o_frame_start |=> !o_frame_start; endproperty
    property p_trg;
        o_frame_start |-> o_pattern_trigger == $past(i_pattern_mode);
    endproperty
    property p_hld; $changed(o_frame_repeat) |-> o_frame_start; endproperty
    property p_pat; i_pattern_mode && o_pix_valid && !o_frame_repeat
        |-> o_pix_data[29:24] == 6'h00; endproperty
    property p_end; $fell(o_pix_valid) |-> $past(o_frame_start, 258);
    endproperty
    property p_beg; $rose(o_pix_valid) |-> $past(o_frame_start, 2);
    endproperty
    a_run: assert property (p_run) else $error("late readout");
    a_one: assert property (p_one) else $error("long start");
    a_trg: assert property (p_trg) else $error("bad trigger");
    a_hld: assert property (p_hld) else $error("repeat moved");
    a_pat: assert property (p_pat) else $error("wide pixel");
    a_end: assert property (p_end) else $error("bad length");
    a_beg: assert property (p_beg) else $error("early readout");
endmodule : prfi_chk
bind prfi_frame_input prfi_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_pattern_mode(i_pattern_mode), .o_pix_data(o_pix_data),
    .o_pix_valid(o_pix_valid), .o_frame_start(o_frame_start),
    .o_frame_repeat(o_frame_repeat), .o_pattern_trigger(o_pattern_trigger));

// File: prfi_frame_input_tb.sv
// Purpose : Self-checking bench for the frame input
// Assumes : Source model drives the pixel port
// Notes   : Each readout follows the next vsync
`timescale 1ns/1ps
module prfi_frame_input_tb;
    import prfi_pkg::*;
    logic        i_clk, i_rst, i_pattern_mode, pclk, de, vs, hs;
    logic        pv, fs, fr, pt;
    logic [29:0] src_lines;
    prfi_pixel_t rgb, pd;
    int          fails, n_checks;
    // ====================
    // Design, source, clock
    prfi_src u_src (.i_lines(src_lines), .o_pclk(pclk), .o_rgb(rgb),
        .o_de(de), .o_vs(vs), .o_hs(hs));
    prfi_frame_input u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_pattern_mode(i_pattern_mode), .port_one_pixel_clock(pclk),
        .port_one_colour_inputs(rgb), .port_one_data_valid(de),
        .port_one_vertical_sync(vs), .port_one_horizontal_sync(hs),
        .o_pix_data(pd), .o_pix_valid(pv), .o_frame_start(fs),
        .o_frame_repeat(fr), .o_pattern_trigger(pt));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ====================
    // Checks and readout
    task automatic chk(input string s, input logic [29:0] e, g);
        n_checks++;
        if (g !== e) fails++;
        if (g !== e) $display("MISMATCH %s exp %h seen %h", s, e, g);
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic run_frame(input string nm, input logic pat, rep,
        input logic [29:0] b);
        logic [29:0] w;
        int          t;
        t = 0;
        fork
            u_src.send_frame(0, 30'h0);
            begin
                while (fs !== 1'b1 && t < 9000) begin
                    @(negedge i_clk);
                    t++;
                end
                chk("start", 30'h1, 30'(fs));
                if (fs !== 1'b1) give_verdict;
                chk("repeat", 30'(rep), 30'(fr));
                chk("trigger", 30'(pat), 30'(pt));
                repeat (2) @(negedge i_clk);
                for (int k = 0; k < 256; k++) begin
                    w = 30'(b + k * 30'h0100401) & src_lines;
                    if (pat) w = {6'h00, w[29:22], w[19:12], w[9:2]};
                    chk("valid", 30'h1, 30'(pv));
                    chk("pixel", w, pd);
                    @(negedge i_clk);
                end
                chk("idle", 30'h0, 30'(pv));
            end
        join
        $display("%s done", nm);
    endtask : run_frame
    task automatic test_video;
        u_src.send_frame(256, 30'h2AA55A5A);
        run_frame("test_video", 1'b0, 1'b0, 30'h2AA55A5A);
    endtask : test_video
    task automatic test_repeat;
        run_frame("test_repeat", 1'b0, 1'b1, 30'h2AA55A5A);
    endtask : test_repeat
    task automatic test_narrow;
        src_lines = 30'h3FCFF3FC;
        u_src.send_frame(256, 30'h3C3C3C3C);
        run_frame("test_narrow", 1'b0, 1'b0, 30'h3C3C3C3C);
        src_lines = 30'h3FFFFFFF;
    endtask : test_narrow
    task automatic test_pattern;
        i_pattern_mode = 1'b1;
        u_src.send_frame(256, 30'h15A5A5A5);
        run_frame("test_pattern", 1'b1, 1'b0, 30'h15A5A5A5);
    endtask : test_pattern
    initial begin
        fails = 0;
        n_checks = 0;
        src_lines = 30'h3FFFFFFF;
        i_rst = 1'b1;
        i_pattern_mode = 1'b0;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (2) u_src.send_frame(0, 30'h0);
        test_video;
        test_repeat;
        test_narrow;
        @(negedge i_clk);
        test_pattern;
        give_verdict;
    end
endmodule : prfi_frame_input_tb

// File: prfi_frame_mem.sv
// Purpose : Two-bank frame store, write on pixel clock, read on system clock
// Assumes : Each bank written and read by disjoint clock domains
// Notes   : Read data comes from a register, one cycle after the address
`timescale 1ns/1ps
module prfi_frame_mem (
    input  wire logic                              i_wclk,
    input  wire logic                              i_we,
    input  wire logic [prfi_pkg::MEM_ABITS-1:0]   i_waddr,
    input  wire logic [prfi_pkg::PIX_BITS-1:0]    i_wdata,
    input  wire logic                              i_clk,
    input  wire logic [prfi_pkg::MEM_ABITS-1:0]   i_raddr,
    output logic      [prfi_pkg::PIX_BITS-1:0]    o_rdata
);
    import prfi_pkg::*;

    // ==========================================================
    // Storage
    logic [PIX_BITS-1:0] mem_ff [0:2*FRAME_WORDS-1];

    always_ff @(posedge i_wclk) begin
        if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    // Bank swap only at frame edges keeps reads off the written bank
    always_ff @(posedge i_clk) begin
        o_rdata <= mem_ff[i_raddr];
    end
endmodule : prfi_frame_mem

// File: prfi_pkg.sv
// Purpose : Shared constants and types for the parallel RGB frame input
// Assumes : One pixel port, one frame of FRAME_WORDS pixels per bank
// Notes   : Colour word is red high, green middle, blue low
package prfi_pkg;
    // ==========================================================
    // Pixel layout
    localparam int CH_BITS      = 10;
    localparam int PIX_BITS     = 30;
    localparam int PAT_CH_BITS  = 8;
    localparam int PAT_BITS     = 24;
    localparam int RED_MSB      = 29;
    localparam int GRN_MSB      = 19;
    localparam int BLU_MSB      = 9;
    // ==========================================================
    // Frame store
    localparam int FRAME_WORDS  = 256;
    localparam int ADDR_BITS    = 8;
    localparam int MEM_ABITS    = 9;
    localparam logic [ADDR_BITS-1:0] ADDR_LAST = 8'hFF;
    localparam logic [ADDR_BITS-1:0] ADDR_ZERO = 8'h00;
    // ==========================================================
    // Timing
    localparam logic [4:0] SYNC_HOLD = 5'h1F;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [CH_BITS-1:0] red;
        logic [CH_BITS-1:0] green;
        logic [CH_BITS-1:0] blue;
    } prfi_pixel_t;

    typedef struct packed {
        prfi_pixel_t colour;
        logic        vsync;
        logic        hsync;
        logic        valid;
    } prfi_port_t;

    typedef enum logic [1:0] {
        PRFI_IDLE = 2'b00,
        PRFI_READ = 2'b01,
        PRFI_LAST = 2'b11
    } prfi_rd_state_t;
endpackage : prfi_pkg

// File: prfi_src_model.sv
// Purpose : Video source for the pixel port
// Assumes : Pixel clock runs free
// Notes   : Idle data toggles, but holds through the two vsync clocks
`timescale 1ns/1ps
module prfi_src (
    input  wire logic [29:0]      i_lines,
    output logic                  o_pclk = 1'b0,
    output prfi_pkg::prfi_pixel_t o_rgb = '0,
    output logic                  o_de = 1'b0,
    output logic                  o_vs = 1'b0,
    output logic                  o_hs = 1'b0
);
    // ====================
    // Sync, gapped pixels, blanking
    initial forever #80 o_pclk = ~o_pclk;
    task automatic send_frame(input int n, input logic [29:0] b);
        @(negedge o_pclk) o_vs <= 1'b1;
        @(negedge o_pclk) o_vs <= 1'b0;
        for (int k = 0; k < 2 * n + 8; k++) begin
            @(negedge o_pclk);
            // Odd pixels are the other controller's share
            o_de <= k[0] == 1'b0 && k < 2 * n;
            o_hs <= k[5:0] == 6'h3F;
            o_rgb <= 30'(k[0] || k >= 2 * n ? ~o_rgb
                : (b + k / 2 * 30'h0100401) & i_lines);
        end
        repeat (80) @(negedge o_pclk) o_rgb <= ~o_rgb;
    endtask : send_frame
endmodule : prfi_src
